// ### design/dps_serial_cmd.sv
// Purpose: Two-wire slave and command interpreter for the wiper
// Assumes: Bus clock is far slower than ref_clk; pins synchronised
// Notes:   Slot storage is flip-flops; nonvolatile timing is modelled
`timescale 1ns/10ps
`default_nettype none
`include "dps_regs.svh"

module dps_serial_cmd
	import dps_pkg::*;
#(
	parameter int unsigned NVW_CYC = `DPS_NVW_CYC
) (
	input  wire logic                  ref_clk,
	input  wire logic                  resetn,
	input  wire logic                  clk_en,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output var  logic                  sda_o,
	output var  logic                  sda_oe_n,
	input  wire logic [1:0]            strap_address_pins,
	input  wire logic                  wp_n,
	output var  logic [`DPS_TAPS-1:0]  tap_on,
	output var  logic [`DPS_POS_W-1:0] wiper_pos,
	output var  logic                  nv_busy
);
	localparam int unsigned WRL_CYC = `DPS_WRL_CYC;

	// ************************************************
	// Pin sampling and bus events
	// ************************************************
	logic       scl_s, sda_s, scl_p_q, sda_p_q;
	logic       nv_busy_q;
	logic [2:0] pin_s;
	wire  [2:0] pin_raw = {wp_n, strap_address_pins};
	wire        wp_s    = pin_s[2];
	wire  [1:0] strap_s = pin_s[1:0];

	dps_sync u_scl (.clk(ref_clk), .resetn(resetn), .en(clk_en),
		.d(scl_i), .q(scl_s));
	dps_sync u_sda (.clk(ref_clk), .resetn(resetn), .en(clk_en),
		.d(sda_i), .q(sda_s));

	// Straps and protect are slow pins but still asynchronous
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_pin
			dps_sync u_pin (.clk(ref_clk), .resetn(resetn), .en(clk_en),
				.d(pin_raw[gi]), .q(pin_s[gi]));
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else if (clk_en) begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Bus is deaf while a nonvolatile write runs
	wire bus_live = !nv_busy_q;
	wire scl_rise = bus_live && scl_s && !scl_p_q;
	wire scl_fall = bus_live && !scl_s && scl_p_q;
	wire start_ev = bus_live && scl_s && scl_p_q && sda_p_q && !sda_s;
	wire stop_ev  = bus_live && scl_s && scl_p_q && !sda_p_q && sda_s;

	// ************************************************
	// State
	// ************************************************
	dps_state_t                  st_q;
	logic [3:0]                  bit_q;
	logic [7:0]                  sh_q;
	logic                        rw_q;
	logic [2:0]                  op_q;
	logic [1:0]                  sel_q;
	logic [1:0]                  dhi_q;
	logic                        ack_q;
	logic                        drive_q;
	logic                        pend_q;
	logic [31:0]                 nv_cnt_q;
	logic [1:0]                  nv_sel_q;
	logic [`DPS_POS_W-1:0]       nv_val_q;
	logic [`DPS_POS_W-1:0]       wiper_position_reg;
	logic [`DPS_POS_W-1:0]       wiper_out_q;
	logic [31:0]                 wrl_cnt_q;
	logic                        boot_q;
	logic [`DPS_POS_W-1:0]       saved_position_slot [4];

	// ************************************************
	// Decode
	// ************************************************
	wire [7:0] byte_in  = {sh_q[6:0], sda_s};
	wire       id_hit   = (byte_in[`DPS_TYPE_MSB:`DPS_TYPE_LSB]
		== `DPS_TYPE_CODE)
		&& (byte_in[`DPS_ADDR_MSB:`DPS_ADDR_LSB]
		== strap_s);
	wire       id_rw    = byte_in[`DPS_RW_BIT];
	wire [2:0] in_op    = byte_in[`DPS_OP_MSB:`DPS_OP_LSB];
	wire [1:0] in_sel   = byte_in[`DPS_SEL_MSB:`DPS_SEL_LSB];
	wire       in_fmt   = (byte_in[4] == 1'b0) && (byte_in[1:0] == 2'b00);
	wire       op_rdw   = rw_q && (in_op == DPS_OP_RD_WIPER);
	wire       op_wrw   = !rw_q && (in_op == DPS_OP_WIPER_SLT);
	wire       op_rds   = rw_q && (in_op == DPS_OP_WIPER_SLT);
	wire       op_wrs   = !rw_q && (in_op == DPS_OP_SLOT_CPY);
	wire       op_cpw   = rw_q && (in_op == DPS_OP_SLOT_CPY);
	wire       op_cps   = !rw_q && (in_op == DPS_OP_CPY_SLOT);
	wire       op_ok    = in_fmt && (op_rdw || op_wrw || op_rds
		|| op_wrs || op_cpw || op_cps);
	wire       op_4b    = !(op_cpw || op_cps);
	wire       is_read  = rw_q && (op_q != DPS_OP_SLOT_CPY);
	wire [`DPS_POS_W-1:0] rd_val = (op_q == DPS_OP_RD_WIPER)
		? wiper_position_reg : saved_position_slot[sel_q];
	wire [7:0] tx_byte  = (st_q == DPS_ST_DHI)
		? {6'h00, rd_val[9:8]} : rd_val[7:0];
	wire       byte_end = scl_rise && (bit_q == 4'h7);
	wire       ack_rise = scl_rise && (bit_q == 4'h8);

	// ************************************************
	// Bit engine and command sequence
	// ************************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			st_q <= DPS_ST_IDLE;
			bit_q <= 4'h0;
			sh_q <= 8'h00;
			rw_q <= 1'b0;
			op_q <= 3'b000;
			sel_q <= 2'b00;
			dhi_q <= 2'b00;
			ack_q <= 1'b0;
			pend_q <= 1'b0;
		end else if (clk_en) begin
			if (start_ev) begin
				st_q <= DPS_ST_ID;
				bit_q <= 4'h0;
				ack_q <= 1'b0;
				pend_q <= 1'b0;
			end else if (stop_ev) begin
				st_q <= DPS_ST_IDLE;
				// Action is spent here, so a later stop cannot repeat it
				pend_q <= 1'b0;
				bit_q <= 4'h0;
				ack_q <= 1'b0;
			end else if (st_q != DPS_ST_IDLE) begin
				// Tail keeps the data byte safe from the stop's clock rise
				if (scl_rise && bit_q < 4'h8 && st_q != DPS_ST_TAIL) begin
					sh_q <= byte_in;
					bit_q <= bit_q + 4'h1;
				end else if (ack_rise) begin
					bit_q <= 4'h0;
					ack_q <= 1'b0;
				end
				if (byte_end) begin
					unique case (st_q)
					DPS_ST_ID: begin
						rw_q <= id_rw;
						ack_q <= id_hit;
						st_q <= id_hit ? DPS_ST_INSTR : DPS_ST_IDLE;
					end
					DPS_ST_INSTR: begin
						op_q <= in_op;
						sel_q <= in_sel;
						ack_q <= op_ok;
						st_q <= !op_ok ? DPS_ST_IDLE
							: (op_4b ? DPS_ST_DHI : DPS_ST_TAIL);
						pend_q <= op_ok && !op_4b;
					end
					DPS_ST_DHI: begin
						dhi_q <= byte_in[1:0];
						ack_q <= !is_read;
						st_q <= DPS_ST_DLO;
					end
					DPS_ST_DLO: begin
						ack_q <= !is_read;
						st_q <= DPS_ST_TAIL;
						pend_q <= !is_read;
					end
					DPS_ST_TAIL: begin
						ack_q <= 1'b0;
					end
					endcase
				end
				// Master not acknowledging a read byte ends the read
				if (ack_rise && is_read && st_q == DPS_ST_DLO && sda_s)
					st_q <= DPS_ST_TAIL;
			end
		end
	end

	// Device transmits only in read data bytes
	wire tx_phase = is_read && (st_q == DPS_ST_DHI || st_q == DPS_ST_DLO);

	// ************************************************
	// Data pin driver, open drain, updated on falling clock
	// ************************************************
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			drive_q <= 1'b0;
		end else if (clk_en) begin
			if (start_ev || stop_ev || !bus_live)
				drive_q <= 1'b0;
			else if (scl_fall) begin
				if (bit_q == 4'h8)
					drive_q <= ack_q;
				else if (tx_phase)
					drive_q <= !tx_byte[3'h7 - bit_q[2:0]];
				else
					drive_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			sda_o <= 1'b0;
			sda_oe_n <= 1'b1;
		end else if (clk_en) begin
			sda_o <= 1'b0;
			sda_oe_n <= !drive_q;
		end
	end

	// ************************************************
	// Wiper, slots and nonvolatile write timer
	// ************************************************
	wire wr_wiper = stop_ev && pend_q && op_q == DPS_OP_WIPER_SLT;
	wire cp_wiper = stop_ev && pend_q && op_q == DPS_OP_SLOT_CPY
		&& rw_q;
	wire nv_req   = stop_ev && pend_q && !rw_q
		&& (op_q == DPS_OP_SLOT_CPY || op_q == DPS_OP_CPY_SLOT);
	wire nv_go    = nv_req && wp_s;
	wire [`DPS_POS_W-1:0] nv_data = (op_q == DPS_OP_CPY_SLOT)
		? wiper_position_reg : {dhi_q, sh_q};

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			nv_busy_q <= 1'b0;
			nv_cnt_q <= 32'h0;
			nv_sel_q <= 2'b00;
			nv_val_q <= `DPS_SLOT_RESET;
			for (int k = 0; k < 4; k++)
				saved_position_slot[k] <= `DPS_SLOT_RESET;
		end else if (clk_en) begin
			if (nv_go) begin
				nv_busy_q <= 1'b1;
				nv_cnt_q <= NVW_CYC - 1;
				nv_sel_q <= sel_q;
				nv_val_q <= nv_data;
			end else if (nv_busy_q) begin
				if (nv_cnt_q == 32'h0) begin
					nv_busy_q <= 1'b0;
					saved_position_slot[nv_sel_q] <= nv_val_q;
				end else
					nv_cnt_q <= nv_cnt_q - 32'h1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wiper_position_reg <= `DPS_SLOT_RESET;
			boot_q <= 1'b1;
		end else if (clk_en) begin
			boot_q <= 1'b0;
			if (boot_q)
				wiper_position_reg <= saved_position_slot[0];
			else if (wr_wiper && !rw_q)
				wiper_position_reg <= {dhi_q, sh_q};
			else if (cp_wiper)
				wiper_position_reg <= saved_position_slot[sel_q];
		end
	end

	// Output lags the register by the response delay
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wiper_out_q <= `DPS_SLOT_RESET;
			wrl_cnt_q <= 32'h0;
		end else if (clk_en) begin
			if (wiper_out_q == wiper_position_reg)
				wrl_cnt_q <= 32'h0;
			else if (wrl_cnt_q >= WRL_CYC - 1)
				wiper_out_q <= wiper_position_reg;
			else
				wrl_cnt_q <= wrl_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wiper_pos <= `DPS_SLOT_RESET;
			nv_busy <= 1'b0;
		end else if (clk_en) begin
			wiper_pos <= wiper_out_q;
			nv_busy <= nv_busy_q;
		end
	end

	dps_tap_decode u_tap (
		.clk   (ref_clk),
		.resetn(resetn),
		.en    (clk_en),
		.pos   (wiper_out_q),
		.tap_on(tap_on)
	);
endmodule // dps_serial_cmd
`default_nettype wire

// ### design/dps_regs.svh
// Purpose: Constants for the serial wiper controller
// Assumes: 100 MHz ref_clk
// Notes:   Times in their own unit, cycle counts derived
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH

// ************************************************
// Identification byte
// ************************************************
`define DPS_TYPE_MSB       7
`define DPS_TYPE_LSB       4
`define DPS_ADDR_MSB       2
`define DPS_ADDR_LSB       1
`define DPS_RW_BIT         0
// Device type code: value is arbitrary
`define DPS_TYPE_CODE      4'h9

// ************************************************
// Instruction byte
// ************************************************
`define DPS_OP_MSB         7
`define DPS_OP_LSB         5
`define DPS_SEL_MSB        3
`define DPS_SEL_LSB        2

// ************************************************
// Reset values and timing
// ************************************************
`define DPS_POS_W          10
`define DPS_TAPS           1024
`define DPS_SLOT_RESET     10'h000
`define DPS_CLK_MHZ        100
`define DPS_NVW_MS         5
`define DPS_NVW_CYC        (`DPS_NVW_MS * 1000 * `DPS_CLK_MHZ)
`define DPS_WRL_NS         1000
`define DPS_WRL_CYC        ((`DPS_WRL_NS * `DPS_CLK_MHZ + 999) / 1000)

`endif

// ### design/dps_pkg.sv
// Purpose: Types for the serial wiper controller
// Assumes: Used with dps_regs.svh
// Notes:   Types only
package dps_pkg;
	typedef enum logic [2:0] {
		DPS_ST_IDLE  = 3'b000,
		DPS_ST_ID    = 3'b001,
		DPS_ST_INSTR = 3'b010,
		DPS_ST_DHI   = 3'b011,
		DPS_ST_DLO   = 3'b100,
		DPS_ST_TAIL  = 3'b101
	} dps_state_t;

	typedef enum logic [2:0] {
		DPS_OP_RD_WIPER  = 3'b100,
		DPS_OP_WIPER_SLT = 3'b101,
		DPS_OP_SLOT_CPY  = 3'b110,
		DPS_OP_CPY_SLOT  = 3'b111
	} dps_op_t;
endpackage

// ### design/dps_sync.sv
// Purpose: Two-stage synchroniser for one bit
// Assumes: d is asynchronous to clk
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module dps_sync (
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic en,
	input  wire logic d,
	output var  logic q
);
	logic meta_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 1'b1;
			q      <= 1'b1;
		end else if (en) begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule // dps_sync
`default_nettype wire

// ### design/dps_tap_decode.sv
// Purpose: One-hot tap switch decode of the wiper position
// Assumes: Position is registered upstream
// Notes:   Registered so exactly one switch is ever on
`timescale 1ns/10ps
`default_nettype none
`include "dps_regs.svh"
module dps_tap_decode (
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  en,
	input  wire logic [`DPS_POS_W-1:0] pos,
	output var  logic [`DPS_TAPS-1:0]  tap_on
);
	genvar i;
	generate
		for (i = 0; i < `DPS_TAPS; i++) begin : g_tap
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn)
					tap_on[i] <= (i == 0);
				else if (en)
					tap_on[i] <= (pos == `DPS_POS_W'(i));
			end
		end
	endgenerate
endmodule // dps_tap_decode
`default_nettype wire

// ### sim/dps_serial_cmd_checker.sv
// Purpose: Port checks for the serial wiper controller
// Assumes: Bound to dps_serial_cmd, link clock near 125 ns
// Notes:   Output windows sized for an 80 ns clock-low phase
`timescale 1ns/10ps
`default_nettype none
`include "dps_regs.svh"
module dps_serial_cmd_checker #(
	parameter int unsigned NVW_CYC = 200
) (
	input wire logic                  ref_clk,
	input wire logic                  resetn,
	input wire logic                  clk_en,
	input wire logic                  scl_i,
	input wire logic                  sda_i,
	input wire logic                  sda_o,
	input wire logic                  sda_oe_n,
	input wire logic [1:0]            strap_address_pins,
	input wire logic                  wp_n,
	input wire logic [`DPS_TAPS-1:0]  tap_on,
	input wire logic [`DPS_POS_W-1:0] wiper_pos,
	input wire logic                  nv_busy
);
	logic        scl_q;
	logic [7:0]  fall_q;
	int unsigned busy_q;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	// Cycles since the bus clock fell, saturating so it never wraps
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			scl_q  <= 1'b1;
			fall_q <= 8'hff;
			busy_q <= 0;
		end else begin
			scl_q  <= scl_i;
			fall_q <= (scl_q && !scl_i) ? 8'h00 : fall_q + {7'h00, ~fall_q[7]};
			busy_q <= nv_busy ? busy_q + 1 : 0;
		end
	end

	property p_onehot; $onehot(tap_on); endproperty
	a_onehot: assert property (p_onehot) else $error("tap not one-hot");
	property p_tap; $stable(wiper_pos) [*4] |-> tap_on == (`DPS_TAPS'(1) << wiper_pos); endproperty
	a_tap: assert property (p_tap) else $error("tap not at wiper");
	property p_sda_low; sda_o == 1'b0; endproperty
	a_sda_low: assert property (p_sda_low) else $error("data driven high");
	property p_oe_win; $changed(sda_oe_n) |-> !scl_i && fall_q <= 8'h07; endproperty
	a_oe_win: assert property (p_oe_win) else $error("data moved late");
	property p_oe_hold; $fell(sda_oe_n) |-> !sda_oe_n [*8]; endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("low bit too short");
	property p_quiet; nv_busy |-> sda_oe_n; endproperty
	a_quiet: assert property (p_quiet) else $error("answer while busy");
	property p_wp; $rose(nv_busy) |-> wp_n; endproperty
	a_wp: assert property (p_wp) else $error("write while protected");
	property p_busy_len; $fell(nv_busy) |-> busy_q + 1 >= NVW_CYC && busy_q <= NVW_CYC + 2; endproperty
	a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
	property p_freeze; !clk_en |=> $stable(wiper_pos) && $stable(nv_busy); endproperty
	a_freeze: assert property (p_freeze) else $error("moved while frozen");
endmodule // dps_serial_cmd_checker

bind dps_serial_cmd dps_serial_cmd_checker #(.NVW_CYC(NVW_CYC)) chk_u (
	.ref_clk(ref_clk), .resetn(resetn), .clk_en(clk_en), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
	.strap_address_pins(strap_address_pins), .wp_n(wp_n),
	.tap_on(tap_on), .wiper_pos(wiper_pos), .nv_busy(nv_busy)
);
`default_nettype wire

// ### sim/dps_bus_master.sv
// Purpose: Two-wire bus master model
// Assumes: Data line pull-up resolved by the bench
// Notes:   Clock stands high between frames; stretch slows the master
`timescale 1ns/10ps
`default_nettype none
module dps_bus_master (
	output var  logic scl,
	output var  logic sda_pull,
	input  wire logic sda
);
	int stretch;
	initial begin
		scl      = 1'b1;
		sda_pull = 1'b0;
		stretch  = 0;
	end
	// Data moves only with the clock low; sampled at the end of high
	task automatic bit_io(input logic b, output logic r);
		#(55 + stretch) sda_pull = ~b;
		#25 scl = 1'b1;
		#40 r = sda;
		#5 scl = 1'b0;
	endtask
	task automatic start();
		if (!scl) begin
			#(55 + stretch) sda_pull = 1'b0;
			#25 scl = 1'b1;
		end
		#40 sda_pull = 1'b1;
		#60 scl = 1'b0;
	endtask
	task automatic stop();
		#(55 + stretch) sda_pull = 1'b1;
		#25 scl = 1'b1;
		#40 sda_pull = 1'b0;
		#60;
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rd(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~ack, r);
	endtask
endmodule // dps_bus_master
`default_nettype wire

// ### sim/tb.sv
// Purpose: Self-checking bench for the serial wiper controller
// Assumes: Bus master model drives the two-wire pins
// Notes:   Short nonvolatile time keeps the run brief
`timescale 1ns/10ps
`default_nettype none
`include "dps_regs.svh"
module tb;
	localparam int unsigned NVW = 200;
	logic                       ref_clk, resetn, clk_en, wp_n;
	logic [1:0]                 strap;
	wire logic                  scl, pull, sda_o, sda_oe_n, nv_busy;
	wire logic [`DPS_TAPS-1:0]  tap_on;
	wire logic [`DPS_POS_W-1:0] wiper_pos;
	int                         num_errors, total_checks;
	logic [31:0]                rnd;
	logic [9:0]                 slot [4];
	logic [9:0]                 w;
	logic [2:0]                 ack;
	logic [15:0]                rv;
	// Open-drain data line with a pull-up
	wire logic sda = ~(pull | (~sda_oe_n & ~sda_o));

	dps_serial_cmd #(.NVW_CYC(NVW)) dut_u (.ref_clk(ref_clk),
		.resetn(resetn), .clk_en(clk_en), .scl_i(scl), .sda_i(sda),
		.sda_o(sda_o), .sda_oe_n(sda_oe_n), .strap_address_pins(strap),
		.wp_n(wp_n), .tap_on(tap_on), .wiper_pos(wiper_pos),
		.nv_busy(nv_busy));
	dps_bus_master bus_u (.scl(scl), .sda_pull(pull), .sda(sda));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic [7:0] idb(input logic rw);
		return {`DPS_TYPE_CODE, 1'b0, strap, rw};
	endfunction
	function automatic logic [7:0] inb(input logic [2:0] op, input logic [1:0] s);
		return {op, 1'b0, s, 2'b00};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Whole command; upper bits of the high data byte are random filler
	task automatic xfer(input logic [7:0] id, input logic [7:0] ins,
			input logic four, input logic [9:0] v);
		logic [7:0] hi, lo;
		logic       a;
		{hi, lo, a, ack} = '0;
		rnd = xs(rnd);
		@(posedge ref_clk) #1;
		bus_u.start();
		bus_u.wr(id, ack[0]);
		if (ack[0])
			bus_u.wr(ins, ack[1]);
		if (ack[1] && four && id[0]) begin
			bus_u.rd(1'b1, hi);
			bus_u.rd(1'b0, lo);
		end else if (ack[1] && four) begin
			bus_u.wr({rnd[7:2], v[9:8]}, ack[2]);
			bus_u.wr(v[7:0], a);
			ack[2] = ack[2] & a;
		end
		rv = {hi, lo};
		bus_u.stop();
	endtask
	// The wiper must lag a stop by the response delay
	task automatic wchk(input logic [9:0] old, input logic [9:0] exp);
		int n;
		n = 0;
		repeat (80) @(posedge ref_clk);
		#1 chk(wiper_pos, old);
		while (wiper_pos !== exp && n < 60) begin
			@(posedge ref_clk) #1;
			n++;
		end
		chk(wiper_pos, exp);
		chk(tap_on[exp], 1'b1);
		if (n == 60)
			complete_run();
	endtask
	task automatic poll();
		logic a;
		int   n;
		a = 1'b0;
		n = 0;
		chk(nv_busy, 1'b1);
		while (!a && n < 20) begin
			bus_u.start();
			bus_u.wr(idb(1'b0), a);
			bus_u.stop();
			n++;
		end
		chk(n > 1, 1'b1);
		chk(a, 1'b1);
		if (!a)
			complete_run();
	endtask
	initial begin
		#1_000_000 num_errors++;
		complete_run();
	end
	initial begin
		{resetn, num_errors, total_checks} = '0;
		{clk_en, wp_n, strap, rnd} = {4'b1110, 32'd85};
		repeat (16) @(posedge ref_clk);
		#1 resetn = 1'b1;
		repeat (8) @(posedge ref_clk);
		#1 chk(wiper_pos, 10'h000);
		xfer(idb(1'b0) ^ 8'h10, inb(3'b101, 2'b00), 1'b1, 10'h3ff);
		chk(ack, 3'b000);
		for (int k = 1; k < 3; k++) begin
			xfer(idb(1'b0) ^ {5'h00, k[1:0], 1'b0}, inb(3'b101, 2'b00), 1'b1, 10'h3ff);
			chk(ack, 3'b000);
		end
		w = rnd[9:0];
		xfer(idb(1'b0), inb(3'b101, 2'b00), 1'b1, w);
		chk(ack, 3'b111);
		wchk(10'h000, w);
		bus_u.stretch = 150;
		xfer(idb(1'b1), inb(3'b100, 2'b00), 1'b1, 10'h000);
		chk(rv, {6'h00, w});
		bus_u.stretch = 0;
		xfer(idb(1'b0), inb(3'b100, 2'b00), 1'b1, 10'h000);
		chk(ack, 3'b001);
		for (int k = 0; k < 4; k++) begin
			slot[k] = rnd[17:8];
			xfer(idb(1'b0), inb(3'b110, k[1:0]), 1'b1, slot[k]);
			chk(ack, 3'b111);
			poll();
		end
		for (int k = 0; k < 4; k++) begin
			xfer(idb(1'b1), inb(3'b101, k[1:0]), 1'b1, 10'h000);
			chk(rv, {6'h00, slot[k]});
		end
		wp_n = 1'b0;
		xfer(idb(1'b0), inb(3'b110, 2'b00), 1'b1, ~slot[0]);
		chk(ack, 3'b111);
		repeat (8) @(posedge ref_clk);
		#1 chk(nv_busy, 1'b0);
		wp_n = 1'b1;
		xfer(idb(1'b1), inb(3'b101, 2'b00), 1'b1, 10'h000);
		chk(rv, {6'h00, slot[0]});
		xfer(idb(1'b1), inb(3'b110, 2'b10), 1'b0, 10'h000);
		chk(ack, 3'b011);
		wchk(w, slot[2]);
		xfer(idb(1'b0), inb(3'b111, 2'b01), 1'b0, 10'h000);
		chk(ack, 3'b011);
		poll();
		xfer(idb(1'b1), inb(3'b101, 2'b01), 1'b1, 10'h000);
		chk(rv, {6'h00, slot[2]});
		@(posedge ref_clk) #1 clk_en = 1'b0;
		repeat (5) @(posedge ref_clk);
		#1 clk_en = 1'b1;
		chk(wiper_pos, slot[2]);
		complete_run();
	end
endmodule // tb
`default_nettype wire
